/* File: src/usb_port_seq.sv */
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// How it works
// (R01) Port-off command: monitor disabled, disconnect detect off
// (R02) Wait for transaction, then power down transceiver
// (R03) Re-enable detect and flag done after 4 ms
// (R04) Bus reset waits for current transaction to finish
// (R05) Reset command: monitor reset, chirp sequence runs alone
// (R06) Reset start: HS transceiver, HS termination, normal mode
// (R07) Reset start arms device chirp detector
// (R08) Device chirp needs 2.5 us continuous J
// (R09) Chirp end in window sets port speed HS
// (R10) Valid chirp end sets chirp-good flag
// (R11) Detector disarmed when device chirp judged complete
// (R12) Software clears chirp-good flag on HS disconnect
// (R13) Host K starts within 100 us
// (R14) Host chirps alternate J/K, 40 to 60 us
// (R15) Host chirping lasts at least 50 ms
// (R16) Reset ends with done flag within 150 us
// (R17) First frame start 120 to 130 us after run
// (R18) Chirp error behaviour chosen by skip setting
// (R19) No chirp end by 7 ms: bad flag, disarm
// (R20) Abort bit stops sequence, self-clears after 100 ns
// (R21) Microsecond and millisecond intervals counted from microsecond tick with margin; J run and abort counted in clock cycles
// (R22) Flags sticky until cleared; busy refuses new commands
module usb_port_seq #(
  parameter int unsigned DISABLE_WAIT_US  = port_seq_pkg::T_DISABLE_MS
                                            * port_seq_pkg::US_PER_MS + 1,
  parameter int unsigned CHIRP_MIN_US     = port_seq_pkg::T_UCH_MS * port_seq_pkg::US_PER_MS + 1,
  parameter int unsigned CHIRP_END_MAX_US = port_seq_pkg::T_UCHEND_MS
                                            * port_seq_pkg::US_PER_MS - 1,
  parameter int unsigned HOST_CHIRP_US    = port_seq_pkg::T_DRSTR_MS
                                            * port_seq_pkg::US_PER_MS + 1
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Transceiver side
  input  wire logic [1:0]                bus_line_condition,
  input  wire logic                      transaction_busy,
  output port_seq_pkg::op_mode_t         transceiver_op_mode,
  output port_seq_pkg::speed_t           transceiver_speed_select,
  output logic                           termination_select,
  output port_seq_pkg::speed_t           port_speed_setting,
  output logic                           chirp_drive_en,
  output logic                           chirp_drive_k,
  output logic                           disconnect_detect_en,
  output logic                           sof_start,
  output port_seq_pkg::host_state_t      host_state_monitor
);
  import port_seq_pkg::*;

  localparam logic [16:0] DIS_US   = 17'(DISABLE_WAIT_US);
  localparam logic [12:0] UCH_US   = 13'(CHIRP_MIN_US);
  localparam logic [16:0] UEND_US  = 17'(CHIRP_END_MAX_US);
  localparam logic [16:0] DRSTR_US = 17'(HOST_CHIRP_US);
  localparam logic [16:0] SOF_US   = 17'(T_SOF_US);
  localparam logic [5:0]  BIT_US   = 6'(T_CHIRP_BIT_US);
  localparam logic [9:0]  J_CYC    = 10'(J_MIN_CYC);
  localparam logic [4:0]  ABT_CYC  = 5'(ABORT_CYC);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  seq_link_if lk ();

  us_tick_gen i_us_tick_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lk      (lk.tick_src)
  );

  line_cond_sync i_line_cond_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (bus_line_condition),
    .lk      (lk.line_src)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take     = awvalid & awready;
  wire w_take      = wvalid & wready;
  wire wr_go       = aw_got & w_got & ~bvalid;
  wire next_aw_got = (aw_got | aw_take) & ~wr_go;
  wire next_w_got  = (w_got | w_take) & ~wr_go;
  wire ar_take     = arvalid & arready;
  wire next_rvalid = ar_take | (rvalid & ~rready);
  wire wr_mapped   = hit(aw_addr, REG_CMD) | hit(aw_addr, REG_STAT) | hit(aw_addr, REG_XCVR);
  wire rd_mapped   = hit(araddr, REG_CMD) | hit(araddr, REG_STAT) | hit(araddr, REG_XCVR);
  wire cmd_wr      = wr_go & hit(aw_addr, REG_CMD) & w_strb[0];
  wire stat_clr_wr = wr_go & hit(aw_addr, REG_STAT) & w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      awready <= ~next_aw_got;
      wready  <= ~next_w_got;
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      bvalid <= wr_go | (bvalid & ~bready);
      if (wr_go) begin
        bresp <= wr_mapped ? RESP_OKAY : RESP_SLV;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  seq_state_t  state;
  seq_state_t  next_state;
  logic [16:0] ph_us;
  logic [12:0] chirp_us;
  logic [5:0]  bit_us;
  logic [9:0]  j_run;
  logic [4:0]  abort_cnt;
  logic        chirp_seen;
  logic        det_armed;
  logic        skip_on_err;
  logic        chirp_good_flag;
  logic        chirp_bad_flag;
  logic        reset_done_flag;
  logic        disable_done_flag;

  wire       tick      = lk.us_tick;
  wire       line_j    = (lk.line_cond == LINE_J);
  wire       line_se0  = (lk.line_cond == LINE_SE0);
  wire [2:0] cmd_code  = w_data[2:0];
  wire       abort_req = cmd_wr & w_data[CMD_ABORT];
  wire       busy      = (state != S_IDLE) | (abort_cnt != 5'h00);
  // Busy sequencer silently ignores new commands
  wire       accept    = cmd_wr & ~abort_req & ~busy; // (R22)
  wire       chirp_end = det_armed & chirp_seen & line_se0;
  wire       good_end  = chirp_end & (chirp_us >= UCH_US) & (ph_us <= UEND_US); // (R09)
  wire       too_late  = det_armed & (ph_us > UEND_US) & ~good_end; // (R19)
  wire       bad_end   = (chirp_end & ~good_end) | too_late;
  wire       enter     = (next_state != state);
  wire       bit_wrap  = tick & (bit_us == BIT_US - 6'h01);

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (accept && cmd_code == CMD_OFF) begin
          next_state = S_OFF_TXN;
        end else if (accept && cmd_code == CMD_RESET) begin
          next_state = S_RST_TXN;
        end else if (accept && cmd_code == CMD_RUN) begin
          next_state = S_SOF_WAIT;
        end
      end
      S_OFF_TXN:  if (!transaction_busy) next_state = S_OFF_HOLD; // (R02)
      S_OFF_HOLD: if (ph_us >= DIS_US) next_state = S_IDLE; // (R03)
      S_RST_TXN:  if (!transaction_busy) next_state = S_RST_DET; // (R04)
      S_RST_DET: begin
        if (good_end) begin
          next_state = S_HCHIRP; // (R13)
        end else if (bad_end) begin
          // Set skip bit: host still chirps once device goes quiet
          next_state = skip_on_err ? S_ERR_WAIT : S_ERR_HOLD; // (R18)
        end
      end
      S_ERR_WAIT: if (line_se0) next_state = S_HCHIRP; // (R18)
      S_ERR_HOLD: if (ph_us >= DRSTR_US) next_state = S_RST_END;
      S_HCHIRP:   if (ph_us >= DRSTR_US) next_state = S_RST_END; // (R15)
      S_RST_END:  next_state = S_IDLE; // (R16)
      S_SOF_WAIT: if (ph_us >= SOF_US) next_state = S_IDLE; // (R17)
      default:    next_state = S_IDLE;
    endcase
    if (abort_req) begin
      next_state = S_IDLE; // (R20)
    end
  end

  // ----------------------------------------------------------------
  // Interval counters
  // ----------------------------------------------------------------
  // One shared phase counter; the tick phase costs under 1 us per interval
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= S_IDLE;
      ph_us    <= 17'h00000;
      chirp_us <= 13'h0000;
      bit_us   <= 6'h00;
      j_run    <= 10'h000;
    end else begin
      state <= next_state;
      if (enter || state == S_IDLE) begin
        ph_us <= 17'h00000; // (R21)
      end else if (tick) begin
        ph_us <= ph_us + 17'h00001; // (R21)
      end
      if (!chirp_seen) begin
        chirp_us <= 13'h0000;
      end else if (tick && chirp_us != 13'h1FFF) begin
        chirp_us <= chirp_us + 13'h0001;
      end
      if (state != S_HCHIRP || bit_wrap) begin
        bit_us <= 6'h00;
      end else if (tick) begin
        bit_us <= bit_us + 6'h01;
      end
      j_run <= (det_armed && line_j && j_run != J_CYC) ? j_run + 10'h001 : 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // Transceiver controls and flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_state_monitor       <= HS_IDLE;
      transceiver_op_mode      <= OP_NORMAL;
      transceiver_speed_select <= SPD_FS;
      termination_select      <= 1'b0;
      port_speed_setting       <= SPD_FS;
      disconnect_detect_en     <= 1'b1;
      chirp_drive_en           <= 1'b0;
      chirp_drive_k            <= 1'b0;
      sof_start                <= 1'b0;
      det_armed                <= 1'b0;
      chirp_seen               <= 1'b0;
      abort_cnt                <= 5'h00;
      skip_on_err              <= RST_SKIP;
    end else begin
      sof_start <= 1'b0;
      if (accept && cmd_code == CMD_OFF) begin
        host_state_monitor   <= HS_DISABLED; // (R01)
        disconnect_detect_en <= 1'b0; // (R01)
      end
      if (accept && cmd_code == CMD_RESET) begin
        host_state_monitor <= HS_RESET; // (R05)
      end
      // Speed selects untouched so a low-speed port stays low-speed
      if (state == S_OFF_TXN && next_state == S_OFF_HOLD) begin
        transceiver_op_mode <= OP_PWRDN; // (R02)
      end
      if (state == S_OFF_HOLD && next_state == S_IDLE && !abort_req) begin
        disconnect_detect_en <= 1'b1; // (R03)
      end
      if (state == S_RST_TXN && next_state == S_RST_DET) begin
        transceiver_speed_select <= SPD_HS; // (R06)
        termination_select      <= 1'b1; // (R06)
        transceiver_op_mode      <= OP_NORMAL; // (R06)
        det_armed                <= 1'b1; // (R07)
      end
      if (j_run == J_CYC) begin
        chirp_seen <= 1'b1; // (R08)
      end
      if (good_end) begin
        port_speed_setting <= SPD_HS; // (R09)
      end
      if (good_end || bad_end || abort_req) begin
        det_armed  <= 1'b0; // (R11)
        chirp_seen <= 1'b0;
      end
      if (next_state == S_HCHIRP && state != S_HCHIRP) begin
        chirp_drive_en <= 1'b1; // (R13)
        chirp_drive_k  <= 1'b1; // (R13)
      end else if (state == S_HCHIRP && next_state != S_HCHIRP) begin
        chirp_drive_en <= 1'b0; // (R15)
        chirp_drive_k  <= 1'b0;
      end else if (state == S_HCHIRP && bit_wrap) begin
        chirp_drive_k <= ~chirp_drive_k; // (R14)
      end
      if (state == S_SOF_WAIT && next_state == S_IDLE && !abort_req) begin
        sof_start          <= 1'b1; // (R17)
        host_state_monitor <= HS_OPER;
      end
      if (abort_req) begin
        abort_cnt <= ABT_CYC; // (R20)
      end else if (abort_cnt != 5'h00) begin
        abort_cnt <= abort_cnt - 5'h01; // (R20)
      end
      if (wr_go && hit(aw_addr, REG_CMD) && w_strb[1]) begin
        skip_on_err <= w_data[CMD_SKIP];
      end
    end
  end

  // Set wins over a clear in the same cycle
  wire [3:0] flag_set = {state == S_OFF_HOLD && next_state == S_IDLE && !abort_req,
                         state == S_RST_END, bad_end, good_end};
  wire [3:0] flag_clr = stat_clr_wr ? w_data[ST_DISDONE:ST_GOOD] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chirp_good_flag   <= 1'b0;
      chirp_bad_flag    <= 1'b0;
      reset_done_flag   <= 1'b0;
      disable_done_flag <= 1'b0;
    end else begin
      chirp_good_flag   <= flag_set[0] | (chirp_good_flag & ~flag_clr[0]); // (R10) (R12)
      chirp_bad_flag    <= flag_set[1] | (chirp_bad_flag & ~flag_clr[1]); // (R19) (R22)
      reset_done_flag   <= flag_set[2] | (reset_done_flag & ~flag_clr[2]); // (R16) (R22)
      disable_done_flag <= flag_set[3] | (disable_done_flag & ~flag_clr[3]); // (R03) (R22)
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] rd_cmd  = {23'h000000, skip_on_err, abort_cnt != 5'h00, 7'h00};
  wire [31:0] rd_stat = {24'h000000, disable_done_flag, reset_done_flag, chirp_bad_flag,
                         chirp_good_flag, busy, host_state_monitor};
  wire [31:0] rd_xcvr = {24'h000000, disconnect_detect_en, port_speed_setting,
                         termination_select, transceiver_speed_select, transceiver_op_mode};
  wire [31:0] rd_word = hit(araddr, REG_CMD)  ? rd_cmd  :
                        hit(araddr, REG_STAT) ? rd_stat :
                        hit(araddr, REG_XCVR) ? rd_xcvr : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take) begin
        rdata <= rd_word;
        rresp <= rd_mapped ? RESP_OKAY : RESP_SLV;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off_start;
    accept && cmd_code == CMD_OFF |=> host_state_monitor == HS_DISABLED && !disconnect_detect_en;
  endproperty
  a_off_start: assert property (p_off_start) else $error("port-off start wrong"); // (R01)

  property p_off_pwrdn;
    state == S_OFF_HOLD |-> transceiver_op_mode == OP_PWRDN && !disconnect_detect_en;
  endproperty
  a_off_pwrdn: assert property (p_off_pwrdn) else $error("hold without power-down"); // (R02)

  property p_dis_done;
    $rose(disable_done_flag) |-> $past(ph_us) >= DIS_US && disconnect_detect_en;
  endproperty
  a_dis_done: assert property (p_dis_done) else $error("disable done too early"); // (R03)

  property p_txn_wait;
    state == S_RST_TXN && transaction_busy |=> state == S_RST_TXN || state == S_IDLE;
  endproperty
  a_txn_wait: assert property (p_txn_wait) else $error("reset ran over a transaction"); // (R04)

  property p_rst_start;
    state == S_RST_DET |-> transceiver_speed_select == SPD_HS && termination_select
                           && transceiver_op_mode == OP_NORMAL && host_state_monitor == HS_RESET;
  endproperty
  a_rst_start: assert property (p_rst_start) else $error("reset setup wrong"); // (R06)

  property p_j_filter;
    $rose(chirp_seen) |-> $past(line_j, 2) && $past(j_run) == J_CYC;
  endproperty
  a_j_filter: assert property (p_j_filter) else $error("chirp seen without 2.5 us J"); // (R08)

  property p_good;
    good_end && !abort_req
      |=> chirp_good_flag && port_speed_setting == SPD_HS && !det_armed ##1 chirp_drive_k;
  endproperty
  a_good: assert property (p_good) else $error("good chirp handling wrong"); // (R10)

  property p_deadline;
    state == S_RST_DET |-> ph_us <= UEND_US + 17'h00001;
  endproperty
  a_deadline: assert property (p_deadline) else $error("chirp detect past 7 ms"); // (R19)

  property p_bit_len;
    chirp_drive_en && $past(chirp_drive_en) && $changed(chirp_drive_k)
      |-> $past(bit_us) == BIT_US - 6'h01;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("host chirp length wrong"); // (R14)

  property p_abort;
    abort_req |=> abort_cnt == ABT_CYC && state == S_IDLE ##25 abort_cnt == 5'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not self-clear"); // (R20)

  property p_sof;
    $rose(sof_start) |-> $past(ph_us) >= SOF_US && host_state_monitor == HS_OPER;
  endproperty
  a_sof: assert property (p_sof) else $error("frame start too early"); // (R17)

  c_good:  cover property (good_end ##[1:1000] chirp_drive_en);
  c_bad:   cover property ($rose(chirp_bad_flag));
  c_off:   cover property ($rose(disable_done_flag));
  c_abort: cover property (abort_req && state != S_IDLE);
endmodule

/* File: shared/port_seq_pkg.sv */
package port_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 4;
  localparam int CLK_MHZ         = 250;
  localparam int CYC_PER_US      = CLK_MHZ;
  localparam int US_PER_MS       = 1000;
  localparam int T_JCHIRP_NS     = 2500;
  localparam int J_MIN_CYC       = (T_JCHIRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_DISABLE_MS    = 4;
  localparam int T_UCH_MS        = 1;
  localparam int T_UCHEND_MS     = 7;
  localparam int T_DRSTR_MS      = 50;
  localparam int T_CHIRP_BIT_US  = 50;
  localparam int T_SOF_US        = 125;
  localparam int T_ABORT_NS      = 100;
  localparam int ABORT_CYC       = T_ABORT_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_XCVR   = 8'h08;
  localparam int         CMD_ABORT  = 7;
  localparam int         CMD_SKIP   = 8;
  localparam int         ST_BUSY    = 3;
  localparam int         ST_GOOD    = 4;
  localparam int         ST_BAD     = 5;
  localparam int         ST_RSTDONE = 6;
  localparam int         ST_DISDONE = 7;
  localparam logic       RST_SKIP   = 1'b0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_RUN = 3'h1, CMD_RESET = 3'h2, CMD_OFF = 3'h3
  } cmd_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_RESET = 3'h1, HS_OPER = 3'h2, HS_DISABLED = 3'h3
  } host_state_t;
  typedef enum logic [1:0] {
    OP_NORMAL = 2'h0, OP_NODRIVE = 2'h1, OP_PWRDN = 2'h3
  } op_mode_t;
  typedef enum logic [1:0] {
    SPD_HS = 2'h0, SPD_FS = 2'h1, SPD_LS = 2'h2
  } speed_t;
  typedef enum logic [1:0] {
    LINE_SE0 = 2'h0, LINE_J = 2'h1, LINE_K = 2'h2, LINE_SE1 = 2'h3
  } line_t;
  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_OFF_TXN  = 4'b0001,
    S_OFF_HOLD = 4'b0011,
    S_RST_TXN  = 4'b0100,
    S_RST_DET  = 4'b0101,
    S_HCHIRP   = 4'b0111,
    S_RST_END  = 4'b0110,
    S_ERR_HOLD = 4'b1100,
    S_ERR_WAIT = 4'b1101,
    S_SOF_WAIT = 4'b1000
  } seq_state_t;

endpackage

/* File: shared/seq_link_if.sv */
`timescale 1ns/1ns
interface seq_link_if;
  logic       us_tick;
  logic [1:0] line_cond;
  modport tick_src (output us_tick);
  modport line_src (output line_cond);
  modport core     (input us_tick, input line_cond);
endinterface

/* File: src/us_tick_gen.sv */
`timescale 1ns/1ns
module us_tick_gen #(
  parameter int unsigned DIV = port_seq_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick out
  seq_link_if.tick_src lk
);
  import port_seq_pkg::*;

  logic [8:0] cnt;
  wire        wrap = (cnt == 9'(DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt        <= 9'h000;
      lk.us_tick <= 1'b0;
    end else begin
      cnt        <= wrap ? 9'h000 : cnt + 9'h001;
      lk.us_tick <= wrap;
    end
  end
endmodule

/* File: src/line_cond_sync.sv */
`timescale 1ns/1ns
module line_cond_sync (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Raw line condition from transceiver pins
  input  wire logic [1:0] raw,
  // Clean line condition
  seq_link_if.line_src    lk
);
  import port_seq_pkg::*;

  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;

  // Change accepted only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1           <= 2'h0;
      s2           <= 2'h0;
      s3           <= 2'h0;
      lk.line_cond <= 2'h0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        lk.line_cond <= s3;
      end
    end
  end
endmodule

/* File: verification/usb_peer_model.sv */
`timescale 1ns/1ns
module usb_peer_model #(
  parameter int CHIRP_CYC = 5000
) (
  // Host side
  input  wire logic       aclk,
  input  wire logic       termination_select,
  input  wire logic       chirp_drive_en,
  input  wire logic       chirp_drive_k,
  // Line
  output logic [1:0]      line
);
  int cnt = 0;
  always @(posedge aclk) begin
    if (!termination_select)
      cnt <= 0;
    else if (cnt < CHIRP_CYC + 600)
      cnt <= cnt + 1;
  end
  // Chirp J 2 us after HS termination, then SE0; host chirp wins the line
  assign line = chirp_drive_en ? (chirp_drive_k ? 2'h2 : 2'h1)
              : !termination_select ? 2'h1
              : (cnt > 500 && cnt <= CHIRP_CYC + 500) ? 2'h1 : 2'h0;
endmodule

/* File: verification/usb_port_seq_bench.sv */
`timescale 1ns/1ns
module usb_port_seq_bench;
  import port_seq_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, busy = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp, line;
  logic        awready, wready, bvalid, arready, rvalid, term, cde, cdk, dde, sof;
  op_mode_t    op;
  speed_t      spd, pspd;
  host_state_t hsm;
  int          err_count = 0, comparisons = 0, n, m;
  row_t        rows[4] = '{'{8'h00, 0, RESP_OKAY}, '{8'h04, 0, RESP_OKAY},
                           '{8'h08, 32'hA4, RESP_OKAY}, '{8'h0C, 0, RESP_SLV}};
  initial forever #2 aclk = ~aclk;
  usb_port_seq #(.DISABLE_WAIT_US(41), .CHIRP_MIN_US(10), .CHIRP_END_MAX_US(40),
    .HOST_CHIRP_US(101)) i_usb_port_seq (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .bus_line_condition(line), .transaction_busy(busy),
    .transceiver_op_mode(op), .transceiver_speed_select(spd), .termination_select(term),
    .port_speed_setting(pspd), .chirp_drive_en(cde), .chirp_drive_k(cdk),
    .disconnect_detect_en(dde), .sof_start(sof), .host_state_monitor(hsm));
  usb_peer_model i_usb_peer_model (.aclk(aclk), .termination_select(term),
    .chirp_drive_en(cde), .chirp_drive_k(cdk), .line(line));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    comparisons++;
    if (v !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, v);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk("bresp", r, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk("rdata", e, rdata);
    chk("rresp", r, rresp);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cuts a hang short; the tests need about 80000 cycles
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].r);
    wr(8'h0C, 32'h3, RESP_SLV);
    // --------------------------------------------------------------
    // Port off, held up by a running transaction
    // --------------------------------------------------------------
    busy <= 1;
    wr(REG_CMD, 32'h3, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("monitor", HS_DISABLED, hsm);
    chk("detect", 0, dde);
    wr(REG_CMD, 32'h2, RESP_OKAY);
    chk("monitor", HS_DISABLED, hsm);
    chk("mode", OP_NORMAL, op);
    busy <= 0;
    for (n = 0; !dde && n < 20000; n++) @(posedge aclk);
    chk("off_wait", 1, n >= 40 * CYC_PER_US);
    chk("mode", OP_PWRDN, op);
    chk("speed", SPD_FS, spd);
    rd(REG_STAT, 32'h83, RESP_OKAY);
    wr(REG_STAT, 32'h80, RESP_OKAY);
    // --------------------------------------------------------------
    // Bus reset with a good peripheral chirp, then run
    // --------------------------------------------------------------
    wr(REG_CMD, 32'h2, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("monitor", HS_RESET, hsm);
    chk("xcvr", {OP_NORMAL, SPD_HS, 1'b1}, {op, spd, term});
    for (n = 0; !cde && n < 40000; n++) @(posedge aclk);
    chk("port_speed", SPD_HS, pspd);
    chk("first_k", 1, cdk);
    for (m = 0; cdk && m < 20000; m++) @(posedge aclk);
    chk("k_hold", 1, m >= 40 * CYC_PER_US && m <= 60 * CYC_PER_US);
    for (n = m; cde && n < 40000; n++) @(posedge aclk);
    chk("chirping", 1, n >= 100 * CYC_PER_US);
    repeat (4) @(posedge aclk);
    rd(REG_STAT, 32'h51, RESP_OKAY);
    wr(REG_STAT, 32'h10, RESP_OKAY);
    rd(REG_STAT, 32'h41, RESP_OKAY);
    wr(REG_CMD, 32'h1, RESP_OKAY);
    for (n = 0; !sof && n < 40000; n++) @(posedge aclk);
    chk("sof_wait", 1, n >= 120 * CYC_PER_US && n <= 130 * CYC_PER_US);
    // --------------------------------------------------------------
    // Reset with no chirp, then abort in the error hold
    // --------------------------------------------------------------
    wr(REG_CMD, 32'h2, RESP_OKAY);
    repeat (11000) @(posedge aclk);
    rd(REG_STAT, 32'h69, RESP_OKAY);
    chk("drive", 0, cde);
    wr(REG_CMD, 32'h80, RESP_OKAY);
    rd(REG_CMD, 32'h80, RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk("monitor", HS_RESET, hsm);
    rd(REG_STAT, 32'h61, RESP_OKAY);
    rd(REG_CMD, 32'h0, RESP_OKAY);
    give_verdict;
  end
endmodule
